// ---- pfpec_pkg.sv ----
// constants package and pin synchroniser for the parallel flash controller
// ==========================================================================
// shared constants
package pfpec_pkg;
	localparam int CLK_PERIOD_NS = 40;
	// byte program must finish within this time
	localparam int PROG_TIME_NS = 20000;
	localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
	// remaining data bits lag the polled bit by at most this time
	localparam int LAG_TIME_NS = 1000;
	localparam int LAG_CYCLES =
		(LAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CNT_W = 9;
	localparam int LAG_CNT_W = 5;
	// pin and array widths
	localparam int HALF_ADDR_W = 11;
	localparam int ADDR_W = 22;
	localparam int ARRAY_ADDR_W = 20;
	localparam int CMD_ADDR_W = 15;
	localparam int DATA_W = 8;
	// command addresses and codes
	localparam logic [14:0] CMD_ADDR_A = 15'h5555;
	localparam logic [14:0] CMD_ADDR_B = 15'h2aaa;
	localparam logic [7:0] CODE_UNLOCK_A = 8'haa;
	localparam logic [7:0] CODE_UNLOCK_B = 8'h55;
	localparam logic [7:0] CODE_PROGRAM = 8'ha0;
	localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CODE_BLOCK_ERASE = 8'h50;
	localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// erase region masks (4 KByte sector, 64 KByte block, whole array)
	localparam logic [19:0] SECTOR_MASK = 20'h00fff;
	localparam logic [19:0] BLOCK_MASK = 20'h0ffff;
	localparam logic [19:0] CHIP_MASK = 20'hfffff;
	// synchroniser reset values
	localparam logic [3:0] CTRL_SYNC_RST = 4'hf;
	localparam logic [18:0] BUS_SYNC_RST = 19'h00000;
	// command sequence states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_C1 = 4'h1,
		ST_C2 = 4'h2,
		ST_PROG_ARM = 4'h3,
		ST_PROG_RUN = 4'h4,
		ST_E3 = 4'h5,
		ST_E4 = 4'h6,
		ST_E5 = 4'h7,
		ST_ERASE_RUN = 4'h8
	} pfpec_state_e;
endpackage : pfpec_pkg

`timescale 1ns/10ps
// ==========================================================================
// two flip-flop synchroniser for asynchronous pins
module pfpec_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// asynchronous in, synchronised out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;

	// first stage feeds only the second stage
	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	// register both stages
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			dout <= sync_d;
		end
	end
endmodule : pfpec_sync

// ---- pfpec_top.sv ----
// parallel programming mode command interface of an 8 Mbit flash
// Overview of operation
// - capture command data on write strobe rise
// - row latched on select fall, column on rise
// - reset pin low resets, data pins undriven
// - data driven: gate low, reset high, write high
// - byte program after four-cycle protected sequence
// - byte program finishes within 20 microseconds
// - busy: ignore commands, reads give status only
// - sector erase via six cycles ending 30H
// - block erase via six cycles ending 50H
// - chip erase: six cycles, 10H at 5555H
// - status reporting starts after launching strobe edge
// - program: poll bit inverted, then true data
// - other bits valid 1 microsecond after completion
// - erase: poll bit zero, then one
// - poll valid after fourth or sixth strobe
// - toggle bit alternates per read while busy
// - toggle valid after fourth or sixth strobe
// - invalid command mid-sequence returns to read
`timescale 1ns/10ps
module pfpec_top
	import pfpec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// device control pins, all active low
	input wire logic reset_pin_n,
	input wire logic out_gate_n,
	input wire logic write_n,
	input wire logic row_col_sel_n,
	// multiplexed address pins
	input wire logic [pfpec_pkg::HALF_ADDR_W-1:0] addr_pins,
	// data pins as input, output and output enable
	input wire logic [pfpec_pkg::DATA_W-1:0] data_in,
	output logic [pfpec_pkg::DATA_W-1:0] data_out,
	output logic data_oe
);
	import pfpec_pkg::*;

	// ======================================================================
	// pin synchronisers
	logic [3:0] ctrl_s;
	logic [18:0] bus_s;
	logic rst_s;
	logic oe_s;
	logic we_s;
	logic rc_s;
	logic [HALF_ADDR_W-1:0] apin_s;
	logic [DATA_W-1:0] dq_s;

	pfpec_sync #(.W(4), .RST_VAL(CTRL_SYNC_RST)) u_ctrl_sync (
		.clk(clk),
		.nrst(nrst),
		.din({reset_pin_n, out_gate_n, write_n, row_col_sel_n}),
		.dout(ctrl_s)
	);

	pfpec_sync #(.W(19), .RST_VAL(BUS_SYNC_RST)) u_bus_sync (
		.clk(clk),
		.nrst(nrst),
		.din({addr_pins, data_in}),
		.dout(bus_s)
	);

	// unpack the synchronised pins
	always_comb begin
		rst_s = ctrl_s[3];
		oe_s = ctrl_s[2];
		we_s = ctrl_s[1];
		rc_s = ctrl_s[0];
		apin_s = bus_s[18:8];
		dq_s = bus_s[7:0];
	end

	// ======================================================================
	// edge detection and address latch
	logic we_p_q;
	logic oe_p_q;
	logic rc_p_q;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	logic wr_edge;
	logic rd_edge;

	always_comb begin
		// a write counts only when reset is high and the gate is high
		wr_edge = we_s & ~we_p_q & oe_s & rst_s;
		rd_edge = ~oe_s & oe_p_q & we_s & rst_s;
		addr_d = addr_q;
		if (~rc_s & rc_p_q) begin
			addr_d[HALF_ADDR_W-1:0] = apin_s;
		end else if (rc_s & ~rc_p_q) begin
			addr_d[ADDR_W-1:HALF_ADDR_W] = apin_s;
		end
	end

	// edge history and address register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			we_p_q <= 1'b1;
			oe_p_q <= 1'b1;
			rc_p_q <= 1'b1;
			addr_q <= '0;
		end else begin
			we_p_q <= we_s;
			oe_p_q <= oe_s;
			rc_p_q <= rc_s;
			addr_q <= addr_d;
		end
	end

	// ======================================================================
	// protected command sequence and internal operations
	logic [DATA_W-1:0] mem [0:(1<<ARRAY_ADDR_W)-1];
	pfpec_state_e state_q;
	pfpec_state_e state_d;
	logic [PROG_CNT_W-1:0] prog_cnt_q;
	logic [PROG_CNT_W-1:0] prog_cnt_d;
	logic [LAG_CNT_W-1:0] lag_q;
	logic [LAG_CNT_W-1:0] lag_d;
	logic [ARRAY_ADDR_W-1:0] prog_addr_q;
	logic [ARRAY_ADDR_W-1:0] prog_addr_d;
	logic [DATA_W-1:0] prog_data_q;
	logic [DATA_W-1:0] prog_data_d;
	logic [ARRAY_ADDR_W-1:0] ptr_q;
	logic [ARRAY_ADDR_W-1:0] ptr_d;
	logic [ARRAY_ADDR_W-1:0] last_q;
	logic [ARRAY_ADDR_W-1:0] last_d;
	logic mem_we;
	logic [ARRAY_ADDR_W-1:0] mem_wa;
	logic [DATA_W-1:0] mem_wd;
	logic [CMD_ADDR_W-1:0] cmd_a;
	logic [ARRAY_ADDR_W-1:0] sector_location;
	logic at_a;
	logic at_b;

	always_comb begin
		cmd_a = addr_q[CMD_ADDR_W-1:0];
		sector_location = addr_q[ARRAY_ADDR_W-1:0];
		at_a = (cmd_a == CMD_ADDR_A);
		at_b = (cmd_a == CMD_ADDR_B);
		state_d = state_q;
		prog_cnt_d = prog_cnt_q;
		lag_d = (lag_q != '0) ? lag_q - 1'b1 : lag_q;
		prog_addr_d = prog_addr_q;
		prog_data_d = prog_data_q;
		ptr_d = ptr_q;
		last_d = last_q;
		mem_we = 1'b0;
		mem_wa = ptr_q;
		mem_wd = ERASED_BYTE;
		case (state_q)
			ST_IDLE: begin
				if (wr_edge && at_a && dq_s == CODE_UNLOCK_A) begin
					state_d = ST_C1;
				end
			end
			// any mismatch abandons the sequence back to read mode
			ST_C1: begin
				if (wr_edge) begin
					state_d = (at_b && dq_s == CODE_UNLOCK_B) ?
						ST_C2 : ST_IDLE;
				end
			end
			ST_C2: begin
				if (wr_edge) begin
					if (at_a && dq_s == CODE_PROGRAM) begin
						state_d = ST_PROG_ARM;
					end else if (at_a && dq_s == CODE_ERASE_SETUP) begin
						state_d = ST_E3;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			// fourth cycle carries target address and data
			ST_PROG_ARM: begin
				if (wr_edge) begin
					prog_addr_d = sector_location;
					prog_data_d = dq_s;
					prog_cnt_d = PROG_CNT_W'(PROG_CYCLES - 1);
					state_d = ST_PROG_RUN;
				end
			end
			// commands are not examined while busy
			ST_PROG_RUN: begin
				if (prog_cnt_q == '0) begin
					mem_we = 1'b1;
					mem_wa = prog_addr_q;
					mem_wd = prog_data_q;
					lag_d = LAG_CNT_W'(LAG_CYCLES);
					state_d = ST_IDLE;
				end else begin
					prog_cnt_d = prog_cnt_q - 1'b1;
				end
			end
			ST_E3: begin
				if (wr_edge) begin
					state_d = (at_a && dq_s == CODE_UNLOCK_A) ?
						ST_E4 : ST_IDLE;
				end
			end
			ST_E4: begin
				if (wr_edge) begin
					state_d = (at_b && dq_s == CODE_UNLOCK_B) ?
						ST_E5 : ST_IDLE;
				end
			end
			// sixth cycle selects the erase region
			ST_E5: begin
				if (wr_edge) begin
					state_d = ST_ERASE_RUN;
					if (dq_s == CODE_SECTOR_ERASE) begin
						ptr_d = sector_location & ~SECTOR_MASK;
						last_d = sector_location | SECTOR_MASK;
					end else if (dq_s == CODE_BLOCK_ERASE) begin
						ptr_d = sector_location & ~BLOCK_MASK;
						last_d = sector_location | BLOCK_MASK;
					end else if (at_a && dq_s == CODE_CHIP_ERASE) begin
						ptr_d = '0;
						last_d = CHIP_MASK;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			// one byte set to all ones per clock
			ST_ERASE_RUN: begin
				mem_we = 1'b1;
				if (ptr_q == last_q) begin
					state_d = ST_IDLE;
				end else begin
					ptr_d = ptr_q + 1'b1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// reset pin abandons any sequence or operation
		if (!rst_s) begin
			state_d = ST_IDLE;
			lag_d = '0;
		end
	end

	// sequence and operation registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			prog_cnt_q <= '0;
			lag_q <= '0;
			prog_addr_q <= '0;
			prog_data_q <= '0;
			ptr_q <= '0;
			last_q <= '0;
		end else begin
			state_q <= state_d;
			prog_cnt_q <= prog_cnt_d;
			lag_q <= lag_d;
			prog_addr_q <= prog_addr_d;
			prog_data_q <= prog_data_d;
			ptr_q <= ptr_d;
			last_q <= last_d;
		end
	end

	// array write port, not reset
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// ======================================================================
	// read path and status bits
	logic busy;
	logic inverted_data_poll_bit;
	logic alternating_status_bit;
	logic toggle_q;
	logic toggle_d;
	logic [DATA_W-1:0] data_d;
	logic oe_d;
	logic [DATA_W-1:0] rd_byte;

	always_comb begin
		busy = (state_q == ST_PROG_RUN) || (state_q == ST_ERASE_RUN);
		rd_byte = mem[sector_location];
		inverted_data_poll_bit = (state_q == ST_PROG_RUN) ?
			~prog_data_q[7] : 1'b0;
		alternating_status_bit = toggle_q;
		// each read while busy flips the toggle bit
		toggle_d = toggle_q ^ (rd_edge & busy);
		if (!rst_s) begin
			toggle_d = 1'b0;
		end
		oe_d = ~oe_s & rst_s & we_s;
		if (busy) begin
			data_d = {inverted_data_poll_bit, alternating_status_bit,
				6'h00};
		end else if (lag_q != '0) begin
			data_d = {rd_byte[7], ~rd_byte[6:0]};
		end else begin
			data_d = rd_byte;
		end
	end

	// output registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			toggle_q <= 1'b0;
			data_out <= '0;
			data_oe <= 1'b0;
		end else begin
			toggle_q <= toggle_d;
			data_out <= data_d;
			data_oe <= oe_d;
		end
	end

	// ======================================================================
	// assertions
	localparam int PROG_MAX = 500;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_prog_start;
		$rose(state_q == ST_PROG_RUN);
	endsequence
	sequence s_erase_start;
		$rose(state_q == ST_ERASE_RUN);
	endsequence

	property p_drive_cause;
		data_oe |-> $past(~oe_s & rst_s & we_s);
	endproperty
	a_drive_cause: assert property (p_drive_cause)
		else $error("data driven without read condition");

	property p_reset_float;
		!rst_s |=> !data_oe ##1 !data_oe || rst_s;
	endproperty
	a_reset_float: assert property (p_reset_float)
		else $error("data driven during reset pin low");

	property p_prog_seq;
		s_prog_start |-> $past(state_q == ST_PROG_ARM && wr_edge);
	endproperty
	a_prog_seq: assert property (p_prog_seq)
		else $error("program started without full sequence");

	property p_prog_time;
		s_prog_start |-> ##[1:PROG_MAX] state_q != ST_PROG_RUN;
	endproperty
	a_prog_time: assert property (p_prog_time)
		else $error("program exceeded its time limit");

	property p_erase_seq;
		s_erase_start |-> $past(state_q == ST_E5 && wr_edge);
	endproperty
	a_erase_seq: assert property (p_erase_seq)
		else $error("erase started without six-cycle sequence");

	property p_busy_ignore;
		(state_q == ST_PROG_RUN && prog_cnt_q > 1 && rst_s)
			|=> state_q == ST_PROG_RUN && $stable(prog_data_q);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore)
		else $error("command accepted while busy");

	property p_prog_poll;
		data_oe && $past(state_q == ST_PROG_RUN)
			|-> data_out[7] == ~prog_data_q[7];
	endproperty
	a_prog_poll: assert property (p_prog_poll)
		else $error("poll bit not inverted during program");

	property p_erase_poll;
		data_oe && $past(state_q == ST_ERASE_RUN) |-> !data_out[7];
	endproperty
	a_erase_poll: assert property (p_erase_poll)
		else $error("poll bit not zero during erase");

	property p_toggle;
		rd_edge && busy && rst_s |=> toggle_q != $past(toggle_q);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("toggle bit did not alternate");

	property p_abort;
		state_q == ST_C1 && wr_edge && dq_s != CODE_UNLOCK_B
			|=> state_q == ST_IDLE;
	endproperty
	a_abort: assert property (p_abort)
		else $error("invalid command did not abort sequence");

	property p_write_qual;
		state_q == ST_IDLE ##1 state_q == ST_C1
			|-> $past(oe_s && rst_s);
	endproperty
	a_write_qual: assert property (p_write_qual)
		else $error("write taken with gate low or reset low");

	property p_lag;
		$fell(state_q == ST_PROG_RUN) && $past(rst_s)
			|-> lag_q == LAG_CYCLES;
	endproperty
	a_lag: assert property (p_lag)
		else $error("lag window not started after program");
endmodule : pfpec_top

// ---- pfpec_prog_model.sv ----
// programmer model that drives the parallel flash pins
`timescale 1ns/10ps
module pfpec_prog_model
	import pfpec_pkg::*;
(
	// clock
	input wire logic clk,
	// control strobes toward the device
	output logic reset_pin_n,
	output logic out_gate_n,
	output logic write_n,
	output logic row_col_sel_n,
	// address and data drive
	output logic [pfpec_pkg::HALF_ADDR_W-1:0] addr_pins,
	output logic [pfpec_pkg::DATA_W-1:0] drv_data,
	output logic drv_en,
	// resolved data bus
	input wire logic [pfpec_pkg::DATA_W-1:0] bus
);
	// ==========================================================
	// idle pin levels at time zero
	initial begin
		reset_pin_n = 1'b1;
		out_gate_n = 1'b1;
		write_n = 1'b1;
		row_col_sel_n = 1'b1;
		addr_pins = 11'h000;
		drv_data = 8'h00;
		drv_en = 1'b0;
	end

	// wait some clocks, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// row half taken on select fall, column half on rise
	task automatic set_addr(input logic [21:0] a);
		addr_pins = a[10:0];
		tick(1);
		row_col_sel_n = 1'b0;
		tick(4);
		addr_pins = a[21:11];
		tick(1);
		row_col_sel_n = 1'b1;
		tick(4);
	endtask : set_addr

	// one write; inh pulls the gate low so the write is inhibited
	task automatic write_cycle(input logic [21:0] a, input logic [7:0] d,
		input logic inh);
		set_addr(a);
		drv_data = d;
		drv_en = 1'b1;
		tick(1);
		write_n = 1'b0;
		tick(3);
		out_gate_n = ~inh;
		tick(3);
		write_n = 1'b1;
		tick(4);
		out_gate_n = 1'b1;
		drv_en = 1'b0;
		tick(1);
	endtask : write_cycle

	// gated read of the currently latched address
	task automatic read_cycle(output logic [7:0] d);
		out_gate_n = 1'b0;
		tick(5);
		d = bus;
		out_gate_n = 1'b1;
		tick(3);
	endtask : read_cycle

	// set reset, gate and write levels and let them settle
	task automatic pins(input logic r, input logic g, input logic w);
		reset_pin_n = r;
		out_gate_n = g;
		write_n = w;
		tick(5);
	endtask : pins

	// first two unlock cycles of every protected sequence
	task automatic unlock();
		write_cycle(22'h005555, CODE_UNLOCK_A, 1'b0);
		write_cycle(22'h002aaa, CODE_UNLOCK_B, 1'b0);
	endtask : unlock

	// four-cycle byte program
	task automatic program_byte(input logic [21:0] a, input logic [7:0] d);
		unlock();
		write_cycle(22'h005555, CODE_PROGRAM, 1'b0);
		write_cycle(a, d, 1'b0);
	endtask : program_byte

	// six-cycle erase, last cycle carries region and code
	task automatic erase(input logic [21:0] a, input logic [7:0] c);
		unlock();
		write_cycle(22'h005555, CODE_ERASE_SETUP, 1'b0);
		unlock();
		write_cycle(a, c, 1'b0);
	endtask : erase
endmodule : pfpec_prog_model

// ---- test_pfpec_top.sv ----
// self-checking bench for the parallel flash command interface
`timescale 1ns/10ps
module test_pfpec_top;
	import pfpec_pkg::*;
	// ==========================================================
	// signals
	logic clk;
	logic nrst;
	logic reset_pin_n;
	logic out_gate_n;
	logic write_n;
	logic row_col_sel_n;
	logic [HALF_ADDR_W-1:0] addr_pins;
	logic [DATA_W-1:0] data_out;
	logic [DATA_W-1:0] drv_data;
	logic [DATA_W-1:0] bus;
	logic [DATA_W-1:0] float_q = 8'h00;
	logic data_oe;
	logic drv_en;
	int cyc = 0;
	int err_total;
	int samples_checked;

	// clock, cycle count and an undriven bus that never settles
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) float_q <= float_q + 8'h01;
	always @(posedge clk) cyc <= cyc + 1;
	assign bus = data_oe ? data_out : (drv_en ? drv_data : float_q);

	// ==========================================================
	// device and programmer
	pfpec_top u_dut (.clk(clk), .nrst(nrst), .reset_pin_n(reset_pin_n),
		.out_gate_n(out_gate_n), .write_n(write_n),
		.row_col_sel_n(row_col_sel_n), .addr_pins(addr_pins),
		.data_in(bus), .data_out(data_out), .data_oe(data_oe));
	pfpec_prog_model u_prog (.clk(clk), .reset_pin_n(reset_pin_n),
		.out_gate_n(out_gate_n), .write_n(write_n),
		.row_col_sel_n(row_col_sel_n), .addr_pins(addr_pins),
		.drv_data(drv_data), .drv_en(drv_en), .bus(bus));

	// ==========================================================
	// helpers
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check8

	task automatic final_report();
		if (err_total == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic read_at(input logic [21:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_prog.set_addr(a);
		u_prog.read_cycle(d);
		check8(d, e);
	endtask : read_at

	// two status reads: poll bit level and toggling
	task automatic busy_check(input logic e7);
		logic [7:0] d0;
		logic [7:0] d1;
		u_prog.read_cycle(d0);
		u_prog.read_cycle(d1);
		check8({7'h0, d0[7]}, {7'h0, e7});
		check8({7'h0, d1[6]}, {7'h0, ~d0[6]});
	endtask : busy_check

	// poll until bit 7 shows e7, bounded
	task automatic wait_done(input logic [21:0] a, input logic e7,
		input int bound);
		logic [7:0] d;
		int i;
		u_prog.set_addr(a);
		for (i = 0; i < bound; i++) begin
			u_prog.read_cycle(d);
			if (d[7] === e7) break;
		end
		if (i == bound) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, d[7], e7);
			final_report();
		end
	endtask : wait_done

	// ==========================================================
	// scenarios
	task automatic s_pins();
		u_prog.pins(1'b1, 1'b1, 1'b1);
		check8({7'h0, data_oe}, 8'h00);
		u_prog.pins(1'b1, 1'b0, 1'b0);
		check8({7'h0, data_oe}, 8'h00);
		u_prog.pins(1'b1, 1'b0, 1'b1);
		u_prog.pins(1'b1, 1'b1, 1'b1);
		u_prog.pins(1'b1, 1'b0, 1'b1);
		check8({7'h0, data_oe}, 8'h01);
		u_prog.pins(1'b0, 1'b0, 1'b1);
		check8({7'h0, data_oe}, 8'h00);
		u_prog.pins(1'b1, 1'b1, 1'b1);
	endtask : s_pins

	task automatic s_sector();
		u_prog.erase(22'h001000, CODE_SECTOR_ERASE);
		busy_check(1'b0);
		u_prog.program_byte(22'h001010, 8'h00);
		wait_done(22'h001000, 1'b1, 800);
		read_at(22'h001000, ERASED_BYTE);
		read_at(22'h001000, ERASED_BYTE);
		read_at(22'h001fff, ERASED_BYTE);
		read_at(22'h001010, ERASED_BYTE);
	endtask : s_sector

	task automatic s_program(input logic [21:0] a, input logic [7:0] d);
		int t0;
		u_prog.program_byte(a, d);
		t0 = cyc;
		busy_check(~d[7]);
		wait_done(a, d[7], 200);
		check8({7'h0, (cyc - t0 <= PROG_CYCLES + 12)}, 8'h01);
		u_prog.tick(LAG_CYCLES + 2);
		read_at(a, d);
	endtask : s_program

	task automatic s_abort();
		u_prog.unlock();
		u_prog.write_cycle(22'h005555, 8'h77, 1'b0);
		u_prog.write_cycle(22'h001300, 8'h00, 1'b0);
		read_at(22'h001300, ERASED_BYTE);
		u_prog.write_cycle(22'h005555, CODE_UNLOCK_A, 1'b0);
		u_prog.write_cycle(22'h002aaa, 8'h77, 1'b0);
		u_prog.write_cycle(22'h005555, CODE_PROGRAM, 1'b0);
		u_prog.write_cycle(22'h001302, 8'h00, 1'b0);
		read_at(22'h001302, ERASED_BYTE);
		u_prog.unlock();
		u_prog.write_cycle(22'h005555, CODE_PROGRAM, 1'b0);
		u_prog.write_cycle(22'h001301, 8'h00, 1'b1);
		read_at(22'h001301, ERASED_BYTE);
		u_prog.pins(1'b0, 1'b1, 1'b1);
		u_prog.pins(1'b1, 1'b1, 1'b1);
		// an armed program left over after reset would take this byte
		u_prog.write_cycle(22'h001303, 8'h00, 1'b0);
		read_at(22'h001303, ERASED_BYTE);
	endtask : s_abort

	task automatic s_block();
		u_prog.erase(22'h010000, CODE_BLOCK_ERASE);
		busy_check(1'b0);
		wait_done(22'h01ffff, 1'b1, 9000);
		read_at(22'h01ffff, ERASED_BYTE);
		read_at(22'h018000, ERASED_BYTE);
		read_at(22'h001234, 8'h3c);
	endtask : s_block

	task automatic s_chip();
		u_prog.erase(22'h005555, CODE_CHIP_ERASE);
		busy_check(1'b0);
		u_prog.pins(1'b0, 1'b0, 1'b1);
		check8({7'h0, data_oe}, 8'h00);
		u_prog.pins(1'b1, 1'b1, 1'b1);
		s_program(22'h01fff0, 8'ha5);
	endtask : s_chip

	// ==========================================================
	// main sequence
	initial begin
		err_total = 0;
		samples_checked = 0;
		nrst = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		u_prog.tick(4);
		s_pins();
		s_sector();
		s_program(22'h001234, 8'h3c);
		s_program(22'h001235, 8'hc3);
		s_abort();
		s_block();
		s_chip();
		final_report();
	end
endmodule : test_pfpec_top
